// ===== rtl/dti_pkg.sv
package dti_pkg;

    // ************************************************************
    // Widths and layout
    // ************************************************************
    localparam int DATA_W    = 8;
    localparam int ADDR_W    = 8;
    localparam int FLAG_W    = 4;
    localparam int WIDE_W    = 16;
    localparam int RAM_DEPTH = 256;

    // Bit positions inside the flag nibble
    localparam int ZERO_FLAG_POS         = 0;
    localparam int CARRY_FLAG_POS        = 1;
    localparam int HALF_CARRY_FLAG_POS   = 2;
    localparam int SIGNED_RANGE_FLAG_POS = 3;

    // ************************************************************
    // Reset values and steps
    // ************************************************************
    localparam logic [DATA_W-1:0] WREG_RST      = 8'h00;
    localparam logic [FLAG_W-1:0] FLAGS_RST     = 4'h0;
    localparam logic [ADDR_W-1:0] STACK_PTR_RST = 8'h00;
    localparam logic [ADDR_W-1:0] STACK_STEP    = 8'h02;
    localparam logic [ADDR_W-1:0] WORD_HI_OFS   = 8'h01;
    localparam logic [DATA_W-1:0] ZERO_BYTE     = 8'h00;
    localparam logic [3:0]        FLAG_PAD      = 4'h0;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_PERIOD_NS = 20;
    localparam int IND_CYCLES    = 2;
    localparam int ONE_CYCLES    = 1;

    // ************************************************************
    // Operations and states
    // ************************************************************
    typedef enum logic [3:0] {
        OP_NOP        = 4'h0,
        OP_LOAD_IMM   = 4'h1,
        OP_STORE_MEM  = 4'h2,
        OP_LOAD_MEM   = 4'h3,
        OP_LOAD_IO    = 4'h4,
        OP_STORE_IO   = 4'h5,
        OP_LOAD_WIDE  = 4'h6,
        OP_STORE_WIDE = 4'h7,
        OP_IND_READ   = 4'h8,
        OP_IND_WRITE  = 4'h9,
        OP_SWAP       = 4'ha,
        OP_SAVE       = 4'hb,
        OP_RESTORE    = 4'hc
    } dti_op_e;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_IND  = 1'b1
    } dti_state_e;

endpackage

// ===== rtl/dti_ram.sv
`timescale 1ns/100ps

module dti_ram #(
    parameter int DEPTH = dti_pkg::RAM_DEPTH
) (
    input  wire logic                          sys_clk,
    input  wire logic                          rst_n,
    input  wire logic                          wa_en,
    input  wire logic [dti_pkg::ADDR_W-1:0]    wa_addr,
    input  wire logic [dti_pkg::DATA_W-1:0]    wa_data,
    input  wire logic                          wb_en,
    input  wire logic [dti_pkg::ADDR_W-1:0]    wb_addr,
    input  wire logic [dti_pkg::DATA_W-1:0]    wb_data,
    input  wire logic [dti_pkg::ADDR_W-1:0]    ra_addr,
    output logic      [dti_pkg::DATA_W-1:0]    ra_data,
    input  wire logic [dti_pkg::ADDR_W-1:0]    rb_addr,
    output logic      [dti_pkg::DATA_W-1:0]    rb_data,
    input  wire logic [dti_pkg::ADDR_W-1:0]    rc_addr,
    output logic      [dti_pkg::DATA_W-1:0]    rc_data
);

    typedef struct packed {
        logic [DEPTH-1:0][dti_pkg::DATA_W-1:0] mem;
    } dti_ram_s;

    dti_ram_s                               s_q;
    dti_ram_s                               s_d;
    logic [DEPTH-1:0][dti_pkg::DATA_W-1:0]  nxt;

    // ************************************************************
    // Per entry write select, port a wins on a clash
    // ************************************************************
    for (genvar i = 0; i < DEPTH; i++) begin : g_entry
        always_comb
        begin
            if (wa_en && wa_addr == dti_pkg::ADDR_W'(i))
                nxt[i] = wa_data;
            else if (wb_en && wb_addr == dti_pkg::ADDR_W'(i))
                nxt[i] = wb_data;
            else
                nxt[i] = s_q.mem[i];
        end
    end

    // Asynchronous reads so single cycle operations see data at once
    assign ra_data = s_q.mem[ra_addr];
    assign rb_data = s_q.mem[rb_addr];
    assign rc_data = s_q.mem[rc_addr];

    always_comb
    begin
        s_d     = s_q;
        s_d.mem = nxt;
    end

    // Cleared at reset so reads never return unknowns
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            s_q <= '0;
        else
            s_q <= s_d;
    end

endmodule // dti_ram

// ===== rtl/dti_exec.sv
// Functional notes
// - Immediate load puts the constant in the work register, flags kept.
// - Memory store writes the work register to memory, no flag changes.
// - Memory load copies the byte, zero flag follows it, other flags kept.
// - IO load copies the IO byte, zero flag follows it, others kept.
// - IO store sends the work register to the IO register, flags kept.
// - Wide counter load copies the 16-bit count into a RAM word.
// - Wide counter store writes a RAM word into the wide counter.
// - Indirect read fetches the byte at the pointer, two cycles, no flags.
// - Indirect write stores to the pointed byte, two cycles, no flags.
// - Swap exchanges work register and memory byte in one cycle, flags kept.
// - Save writes flags and work register at the stack pointer, adds two.
// - Restore subtracts two, then reloads flags and work register.
// - Zero flag is one when the governing result is zero.
`timescale 1ns/100ps

module dti_exec #(
    parameter int RAM_DEPTH = dti_pkg::RAM_DEPTH
) (
    input  wire logic                          sys_clk,
    input  wire logic                          rst_n,
    input  wire logic                          op_valid,
    input  wire dti_pkg::dti_op_e              op_code,
    input  wire logic [dti_pkg::DATA_W-1:0]    op_imm,
    input  wire logic [dti_pkg::ADDR_W-1:0]    op_addr,
    input  wire logic [dti_pkg::DATA_W-1:0]    io_rdata,
    input  wire logic [dti_pkg::WIDE_W-1:0]    wide_counter,
    input  wire logic                          stack_ptr_load,
    input  wire logic [dti_pkg::ADDR_W-1:0]    stack_ptr_val,
    input  wire logic [dti_pkg::ADDR_W-1:0]    view_addr,
    output logic      [dti_pkg::DATA_W-1:0]    work_register_q,
    output logic      [dti_pkg::FLAG_W-1:0]    flags_q,
    output logic      [dti_pkg::ADDR_W-1:0]    stack_pointer_q,
    output logic                               busy_q,
    output logic                               done_q,
    output logic                               io_we_q,
    output logic      [dti_pkg::ADDR_W-1:0]    io_addr_q,
    output logic      [dti_pkg::DATA_W-1:0]    io_wdata_q,
    output logic                               wide_we_q,
    output logic      [dti_pkg::WIDE_W-1:0]    wide_wdata_q,
    output logic      [dti_pkg::DATA_W-1:0]    view_data_q
);

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        dti_pkg::dti_state_e          state;
        logic [dti_pkg::DATA_W-1:0]   wreg;
        logic [dti_pkg::FLAG_W-1:0]   flags;
        logic [dti_pkg::ADDR_W-1:0]   stack_ptr;
        logic [dti_pkg::ADDR_W-1:0]   ptr;
        logic                         ind_wr;
        logic                         busy;
        logic                         done;
        logic                         io_we;
        logic [dti_pkg::ADDR_W-1:0]   io_addr;
        logic [dti_pkg::DATA_W-1:0]   io_wdata;
        logic                         wide_we;
        logic [dti_pkg::WIDE_W-1:0]   wide_wdata;
        logic [dti_pkg::DATA_W-1:0]   view;
    } dti_exec_s;

    localparam dti_exec_s EXEC_RST = '{
        state:      dti_pkg::ST_IDLE,
        wreg:       dti_pkg::WREG_RST,
        flags:      dti_pkg::FLAGS_RST,
        stack_ptr:  dti_pkg::STACK_PTR_RST,
        ptr:        dti_pkg::ZERO_BYTE,
        ind_wr:     1'b0,
        busy:       1'b0,
        done:       1'b0,
        io_we:      1'b0,
        io_addr:    dti_pkg::ZERO_BYTE,
        io_wdata:   dti_pkg::ZERO_BYTE,
        wide_we:    1'b0,
        wide_wdata: 16'h0000,
        view:       dti_pkg::ZERO_BYTE
    };

    dti_exec_s                    s_q;
    dti_exec_s                    s_d;
    logic                         wa_en;
    logic [dti_pkg::ADDR_W-1:0]   wa_addr;
    logic [dti_pkg::DATA_W-1:0]   wa_data;
    logic                         wb_en;
    logic [dti_pkg::ADDR_W-1:0]   wb_addr;
    logic [dti_pkg::DATA_W-1:0]   wb_data;
    logic [dti_pkg::ADDR_W-1:0]   ra_addr;
    logic [dti_pkg::DATA_W-1:0]   ra_data;
    logic [dti_pkg::ADDR_W-1:0]   rb_addr;
    logic [dti_pkg::DATA_W-1:0]   rb_data;
    logic [dti_pkg::DATA_W-1:0]   rc_data;
    logic                         op_take;

    // Operation accepted only while idle; requests during busy are dropped
    assign op_take = op_valid && (s_q.state == dti_pkg::ST_IDLE);

    // ************************************************************
    // Data memory
    // ************************************************************
    dti_ram #(
        .DEPTH   (RAM_DEPTH)
    ) u_ram (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .wa_en   (wa_en),
        .wa_addr (wa_addr),
        .wa_data (wa_data),
        .wb_en   (wb_en),
        .wb_addr (wb_addr),
        .wb_data (wb_data),
        .ra_addr (ra_addr),
        .ra_data (ra_data),
        .rb_addr (rb_addr),
        .rb_data (rb_data),
        .rc_addr (view_addr),
        .rc_data (rc_data)
    );

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb
    begin
        s_d        = s_q;
        s_d.done   = 1'b0;
        s_d.io_we  = 1'b0;
        s_d.wide_we = 1'b0;
        s_d.view   = rc_data;
        wa_en      = 1'b0;
        wa_addr    = op_addr;
        wa_data    = s_q.wreg;
        wb_en      = 1'b0;
        wb_addr    = op_addr + dti_pkg::WORD_HI_OFS;
        wb_data    = s_q.wreg;
        ra_addr    = op_addr;
        rb_addr    = op_addr + dti_pkg::WORD_HI_OFS;
        case (s_q.state)
            dti_pkg::ST_IDLE:
            begin
                // Direct load only when no operation is taken this cycle
                if (stack_ptr_load && !op_take)
                    s_d.stack_ptr = stack_ptr_val;
                if (op_take)
                begin
                    s_d.done = 1'b1;
                    case (op_code)
                        dti_pkg::OP_LOAD_IMM:
                            s_d.wreg = op_imm;
                        dti_pkg::OP_STORE_MEM:
                            wa_en = 1'b1;
                        dti_pkg::OP_LOAD_MEM:
                        begin
                            s_d.wreg = ra_data;
                            s_d.flags[dti_pkg::ZERO_FLAG_POS] =
                                (ra_data == dti_pkg::ZERO_BYTE);
                        end
                        dti_pkg::OP_LOAD_IO:
                        begin
                            s_d.wreg = io_rdata;
                            s_d.flags[dti_pkg::ZERO_FLAG_POS] =
                                (io_rdata == dti_pkg::ZERO_BYTE);
                        end
                        dti_pkg::OP_STORE_IO:
                        begin
                            s_d.io_we    = 1'b1;
                            s_d.io_addr  = op_addr;
                            s_d.io_wdata = s_q.wreg;
                        end
                        dti_pkg::OP_LOAD_WIDE:
                        begin
                            // Low byte at the word address, high byte above it
                            wa_en   = 1'b1;
                            wa_data = wide_counter[7:0];
                            wb_en   = 1'b1;
                            wb_data = wide_counter[15:8];
                        end
                        dti_pkg::OP_STORE_WIDE:
                        begin
                            s_d.wide_we    = 1'b1;
                            s_d.wide_wdata = {rb_data, ra_data};
                        end
                        dti_pkg::OP_IND_READ,
                        dti_pkg::OP_IND_WRITE:
                        begin
                            // High pointer byte unused: software holds it at zero
                            s_d.ptr    = ra_data;
                            s_d.ind_wr = (op_code == dti_pkg::OP_IND_WRITE);
                            s_d.state  = dti_pkg::ST_IND;
                            s_d.busy   = 1'b1;
                            s_d.done   = 1'b0;
                        end
                        dti_pkg::OP_SWAP:
                        begin
                            wa_en    = 1'b1;
                            s_d.wreg = ra_data;
                        end
                        dti_pkg::OP_SAVE:
                        begin
                            // Work register at the pointer, flags one above
                            wa_en   = 1'b1;
                            wa_addr = s_q.stack_ptr;
                            wb_en   = 1'b1;
                            wb_addr = s_q.stack_ptr + dti_pkg::WORD_HI_OFS;
                            wb_data = {dti_pkg::FLAG_PAD, s_q.flags};
                            s_d.stack_ptr = s_q.stack_ptr + dti_pkg::STACK_STEP;
                        end
                        dti_pkg::OP_RESTORE:
                        begin
                            s_d.stack_ptr = s_q.stack_ptr - dti_pkg::STACK_STEP;
                            ra_addr   = s_d.stack_ptr;
                            rb_addr   = s_d.stack_ptr + dti_pkg::WORD_HI_OFS;
                            s_d.wreg  = ra_data;
                            s_d.flags = rb_data[dti_pkg::FLAG_W-1:0];
                        end
                        default:
                            s_d.done = 1'b1;
                    endcase
                end
            end
            dti_pkg::ST_IND:
            begin
                // Second cycle: access the byte the pointer names
                ra_addr  = s_q.ptr;
                wa_addr  = s_q.ptr;
                wa_en    = s_q.ind_wr;
                if (!s_q.ind_wr)
                    s_d.wreg = ra_data;
                s_d.state = dti_pkg::ST_IDLE;
                s_d.busy  = 1'b0;
                s_d.done  = 1'b1;
            end
            default:
            begin
                s_d.state = dti_pkg::ST_IDLE;
                s_d.busy  = 1'b0;
            end
        endcase
    end

    // Synchronous reset to constants only
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            s_q <= EXEC_RST;
        else
            s_q <= s_d;
    end

    // ************************************************************
    // Outputs, all straight from state flops
    // ************************************************************
    assign work_register_q = s_q.wreg;
    assign flags_q         = s_q.flags;
    assign stack_pointer_q = s_q.stack_ptr;
    assign busy_q          = s_q.busy;
    assign done_q          = s_q.done;
    assign io_we_q         = s_q.io_we;
    assign io_addr_q       = s_q.io_addr;
    assign io_wdata_q      = s_q.io_wdata;
    assign wide_we_q       = s_q.wide_we;
    assign wide_wdata_q    = s_q.wide_wdata;
    assign view_data_q     = s_q.view;

    // ************************************************************
    // Checks
    // ************************************************************
    AST_IMM: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        op_take && op_code == dti_pkg::OP_LOAD_IMM |=>
            work_register_q == $past(op_imm) && $stable(flags_q))
        else $error("immediate load wrong");

    AST_MEM_WR: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        op_take && op_code == dti_pkg::OP_STORE_MEM |->
            wa_en && wa_addr == op_addr && wa_data == work_register_q
            ##1 $stable(flags_q))
        else $error("memory store wrong");

    AST_MEM_RD: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        op_take && op_code == dti_pkg::OP_LOAD_MEM |=>
            work_register_q == $past(ra_data)
            && flags_q[0] == (work_register_q == 8'h00)
            && flags_q[3:1] == $past(flags_q[3:1]))
        else $error("memory load wrong");

    AST_IO_RD: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        op_take && op_code == dti_pkg::OP_LOAD_IO |=>
            work_register_q == $past(io_rdata)
            && flags_q[0] == ($past(io_rdata) == 8'h00)
            && flags_q[3:1] == $past(flags_q[3:1]))
        else $error("IO load wrong");

    AST_IO_WR: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        op_take && op_code == dti_pkg::OP_STORE_IO |=>
            io_we_q && io_wdata_q == $past(work_register_q) && io_addr_q == $past(op_addr)
            && $stable(flags_q) ##1 io_we_q == $past(op_take && op_code == dti_pkg::OP_STORE_IO))
        else $error("IO store wrong");

    AST_WIDE_LD: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        op_take && op_code == dti_pkg::OP_LOAD_WIDE |->
            wa_en && wb_en && wa_data == wide_counter[7:0]
            && wb_data == wide_counter[15:8] && wb_addr == wa_addr + 8'h01)
        else $error("wide counter load wrong");

    AST_WIDE_ST: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        op_take && op_code == dti_pkg::OP_STORE_WIDE |=>
            wide_we_q && wide_wdata_q == $past({rb_data, ra_data})
            && $stable(flags_q))
        else $error("wide counter store wrong");

    AST_IND: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        op_take && (op_code == dti_pkg::OP_IND_READ
            || op_code == dti_pkg::OP_IND_WRITE) |=>
            busy_q && !done_q ##1 !busy_q && done_q && flags_q == $past(flags_q, 2))
        else $error("indirect timing wrong");

    AST_SWAP: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        op_take && op_code == dti_pkg::OP_SWAP |->
            wa_en && wa_data == work_register_q
            ##1 work_register_q == $past(ra_data) && $stable(flags_q))
        else $error("swap wrong");

    AST_SAVE: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        op_take && op_code == dti_pkg::OP_SAVE |=>
            stack_pointer_q == $past(stack_pointer_q) + 8'h02 && $stable(flags_q))
        else $error("save wrong");

    AST_RESTORE: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        op_take && op_code == dti_pkg::OP_RESTORE |=>
            stack_pointer_q == $past(stack_pointer_q) - 8'h02
            && flags_q == $past(rb_data[3:0]) && work_register_q == $past(ra_data))
        else $error("restore wrong");

    AST_ONE: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        op_take && op_code != dti_pkg::OP_IND_READ
            && op_code != dti_pkg::OP_IND_WRITE |=> done_q && !busy_q)
        else $error("single cycle operation late");

endmodule // dti_exec

// ===== sim/dti_far_side.sv
`timescale 1ns/100ps

module dti_far_side (
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic [7:0]  op_addr,
    input  wire logic        io_we,
    input  wire logic [7:0]  io_addr,
    input  wire logic [7:0]  io_wdata,
    input  wire logic        wide_we,
    input  wire logic [15:0] wide_wdata,
    output logic      [7:0]  io_rdata,
    output logic      [15:0] wide_counter
);
    // ************************************************************
    // IO registers and wide counter
    // ************************************************************
    logic [7:0] io_regs [256];

    // IO read answers at once for the addressed register
    assign io_rdata = io_regs[op_addr];

    // Counter runs free so loads see a moving value; a store overrides it
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            wide_counter <= 16'h00f0;
            for (int i = 0; i < 256; i++)
            begin
                io_regs[i] <= 8'(i) & 8'hf0; // Low addresses read zero
            end
        end
        else
        begin
            wide_counter <= wide_we ? wide_wdata : wide_counter + 16'h0001;
            if (io_we)
                io_regs[io_addr] <= io_wdata;
        end
    end
endmodule // dti_far_side

// ===== sim/tb.sv
`timescale 1ns/100ps

module tb;
    // ************************************************************
    // Signals and reference state
    // ************************************************************
    logic             sys_clk, rst_n, op_valid, stack_ptr_load, busy_q, done_q;
    logic             io_we_q, wide_we_q;
    dti_pkg::dti_op_e op_code, op;
    logic [7:0]       op_imm, op_addr, io_rdata, stack_ptr_val, view_addr;
    logic [7:0]       work_register_q, stack_pointer_q, io_addr_q, io_wdata_q, view_data_q;
    logic [3:0]       flags_q, m_f;
    logic [15:0]      wide_counter, wide_wdata_q, cnt;
    logic [7:0]       ram [256];
    logic [7:0]       m_w, m_sp, io_v, a;
    int               bad_count = 0;
    int               n_checks = 0;

    dti_exec dut (.sys_clk, .rst_n, .op_valid, .op_code, .op_imm, .op_addr, .io_rdata,
        .wide_counter, .stack_ptr_load, .stack_ptr_val, .view_addr, .work_register_q,
        .flags_q, .stack_pointer_q, .busy_q, .done_q, .io_we_q, .io_addr_q, .io_wdata_q,
        .wide_we_q, .wide_wdata_q, .view_data_q);

    dti_far_side far (.sys_clk, .rst_n, .op_addr, .io_we(io_we_q), .io_addr(io_addr_q),
        .io_wdata(io_wdata_q), .wide_we(wide_we_q), .wide_wdata(wide_wdata_q),
        .io_rdata, .wide_counter);

    // Free-running system clock
    initial sys_clk = 1'b0;
    always #(dti_pkg::CLK_PERIOD_NS / 2) sys_clk = ~sys_clk;

    // ************************************************************
    // Checking and closing
    // ************************************************************
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // One request taken at the next edge; leaves op_valid high for back-to-back use
    task automatic do_op(input dti_pkg::dti_op_e o, input logic [7:0] ad, input logic [7:0] im);
        logic [7:0] p;
        op_valid = 1'b1;
        op_code = o;
        op_addr = ad;
        op_imm = im;
        #1;
        io_v = io_rdata;
        cnt = wide_counter;
        p = ram[ad];
        @(negedge sys_clk);
        case (o)
            dti_pkg::OP_LOAD_IMM:   m_w = im;
            dti_pkg::OP_STORE_MEM:  ram[ad] = m_w;
            dti_pkg::OP_LOAD_MEM:   m_w = ram[ad];
            dti_pkg::OP_LOAD_IO:    m_w = io_v;
            dti_pkg::OP_LOAD_WIDE:  {ram[ad + 8'h01], ram[ad]} = cnt;
            dti_pkg::OP_IND_READ:   m_w = ram[p];
            dti_pkg::OP_IND_WRITE:  ram[p] = m_w;
            dti_pkg::OP_SWAP:       {m_w, ram[ad]} = {ram[ad], m_w};
            dti_pkg::OP_SAVE:
            begin
                ram[m_sp] = m_w;
                ram[m_sp + 8'h01] = {4'h0, m_f};
                m_sp = m_sp + 8'h02;
            end
            dti_pkg::OP_RESTORE:
            begin
                m_sp = m_sp - 8'h02;
                {m_f, m_w} = {ram[m_sp + 8'h01][3:0], ram[m_sp]};
            end
            default: ;
        endcase
        if (o == dti_pkg::OP_LOAD_MEM || o == dti_pkg::OP_LOAD_IO)
            m_f[0] = (m_w == 8'h00);
        if (o == dti_pkg::OP_IND_READ || o == dti_pkg::OP_IND_WRITE)
        begin
            check(16'({busy_q, done_q}), 16'h0002);
            op_code = dti_pkg::OP_LOAD_IMM; // Must be ignored while busy
            op_imm = ~m_w;
            @(negedge sys_clk);
        end
        check(16'({done_q, busy_q}), 16'h0002);
        check(16'(work_register_q), 16'(m_w));
        check(16'(flags_q), 16'(m_f));
        check(16'(stack_pointer_q), 16'(m_sp));
        check(16'(io_we_q), 16'(o == dti_pkg::OP_STORE_IO));
        if (o == dti_pkg::OP_STORE_IO)
            check({io_addr_q, io_wdata_q}, {ad, m_w});
        check(16'(wide_we_q), 16'(o == dti_pkg::OP_STORE_WIDE));
        if (o == dti_pkg::OP_STORE_WIDE)
            check(wide_wdata_q, {ram[ad + 8'h01], ram[ad]});
    endtask

    // ************************************************************
    // Main sequence
    // ************************************************************
    // Random operation mix, pointers prepared before each indirect move
    initial
    begin
        {rst_n, op_valid, stack_ptr_load} = 3'b000;
        op_code = dti_pkg::OP_NOP;
        {op_imm, op_addr, stack_ptr_val, view_addr} = 32'h0;
        {m_w, m_f, m_sp} = 20'h0;
        for (int i = 0; i < 256; i++)
            ram[i] = 8'h00;
        void'($urandom(82));
        repeat (10) @(negedge sys_clk);
        rst_n = 1'b1;
        // Corner case: back-to-back IO stores, then a read of the second register
        do_op(dti_pkg::OP_STORE_IO, 8'h05, 8'h00);
        do_op(dti_pkg::OP_STORE_IO, 8'h06, 8'h00);
        do_op(dti_pkg::OP_LOAD_IO, 8'h06, 8'h00);
        repeat (400)
        begin
            op = dti_pkg::dti_op_e'($urandom_range(12));
            a = 8'($urandom);
            if (op == dti_pkg::OP_IND_READ || op == dti_pkg::OP_IND_WRITE)
            begin
                do_op(dti_pkg::OP_LOAD_IMM, a, 8'h00);
                do_op(dti_pkg::OP_STORE_MEM, a + 8'h01, 8'h00);
                do_op(dti_pkg::OP_LOAD_IMM, a, 8'($urandom));
                do_op(dti_pkg::OP_STORE_MEM, a, 8'h00);
                do_op(dti_pkg::OP_LOAD_IMM, a, 8'($urandom));
            end
            do_op(op, a, 8'($urandom));
            if ($urandom_range(3) == 0)
            begin
                op_valid = 1'b0;
                stack_ptr_load = 1'b1;
                stack_ptr_val = 8'($urandom);
                m_sp = stack_ptr_val;
                @(negedge sys_clk);
                stack_ptr_load = 1'b0;
            end
        end
        op_valid = 1'b0;
        for (int i = 0; i < 256; i++)
        begin
            view_addr = 8'(i);
            @(negedge sys_clk);
            check(16'(view_data_q), 16'(ram[i]));
        end
        wrap_up();
    end

    // Cuts a hang short well beyond the expected run of about 1100 cycles
    initial
    begin
        #1000000;
        bad_count++;
        wrap_up();
    end
endmodule // tb
